// file: bench/serial_port_host_programming_tb.sv
/*
 * Testbench: programming sequence, address pairs, ready flags, serial frames.
 * Assumes spi_core with DW of 8 and a 16-clock character tick.
 */
`timescale 1ns/1ps
module serial_port_host_programming_tb
    import spi_pkg::*;
();
    logic        clk_sys;
    logic        rst;
    logic [7:0]  io_addr;
    logic        io_wr;
    logic        io_rd;
    logic [7:0]  io_wdata;
    logic [7:0]  io_rdata_ff;
    logic        rx_valid;
    logic [7:0]  rx_data;
    logic        tx_ready_flag_ff;
    logic        rx_ready_flag_ff;
    logic        txd_ff;
    logic [7:0]  mode_word_ff;
    logic [7:0]  sync1_ff;
    logic [7:0]  sync2_ff;
    int          n_errors = 0;
    int          checks = 0;
    int          cyc = 0;
    int          seed = 32'hE507;
    logic        rd_seen = 1'b0;
    logic [15:0] note;
    logic [10:0] fr;
    logic        par_on = 1'b0;
    int          nb;
    logic [7:0]  d;
    logic [7:0]  s;
    bit          ok;
    logic [7:0]  exp_tx[$];

    spi_core #(.DW(8)) uut (.clk_sys(clk_sys), .rst(rst), .io_addr(io_addr), .io_wr(io_wr),
        .io_rd(io_rd), .io_wdata(io_wdata), .io_rdata_ff(io_rdata_ff), .rx_valid(rx_valid),
        .rx_data(rx_data), .tx_ready_flag_ff(tx_ready_flag_ff),
        .rx_ready_flag_ff(rx_ready_flag_ff), .txd_ff(txd_ff), .mode_word_ff(mode_word_ff),
        .sync1_ff(sync1_ff), .sync2_ff(sync2_ff));
    spi_host host (.clk_sys(clk_sys), .io_addr(io_addr), .io_wr(io_wr), .io_rd(io_rd),
        .io_wdata(io_wdata), .io_rdata_ff(io_rdata_ff));

    // Free-running 100 MHz clock.
    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checks++;
        if (got !== exp) begin
            n_errors++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic results();
        $display("checks=%0d n_errors=%0d", checks, n_errors);
        if (n_errors == 0 && checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    // A hang counts as a mismatch; the sequence needs about a thousand cycles.
    always @(posedge clk_sys) begin
        cyc++;
        if (cyc == 20000) begin
            n_errors++;
            results();
        end
    end

    // Read data is registered, so the oldest note is compared half a cycle later.
    always @(posedge clk_sys) rd_seen <= io_rd;
    always @(negedge clk_sys) begin
        if (rd_seen && host.exp_q.size() > 0) begin
            note = host.exp_q.pop_front();
            if (note[15:8] != 8'h00) begin
                chk(io_rdata_ff & note[15:8], note[7:0]);
            end
        end
    end

    // Frames are sampled mid-bit; a frame nobody wrote is itself a mismatch.
    initial begin
        forever begin
            @(negedge txd_ff);
            if (!rst) begin
                // No wait after the stop bit, or a back-to-back start edge is missed.
                nb = par_on ? 11 : 10;
                repeat (8) @(posedge clk_sys);
                for (int b = 0; b < nb; b++) begin
                    fr[b] = txd_ff;
                    if (b < nb - 1) begin
                        repeat (16) @(posedge clk_sys);
                    end
                end
                chk({6'h00, fr[nb-1], fr[0]}, 8'h02);
                if (par_on) chk({7'h00, fr[9]}, {7'h00, ~^fr[8:1]});
                if (exp_tx.size() == 0) begin
                    chk(fr[8:1], ~fr[8:1]);
                end else begin
                    chk(fr[8:1], exp_tx.pop_front());
                end
            end
        end
    end

    initial begin
        rst = 1'b1;
        rx_valid = 1'b0;
        rx_data = 8'h00;
        host.init_on = 1'b1;
        repeat (16) @(negedge clk_sys);
        rst = 1'b0;
        // single-sync mode word, one sync byte, then a command.
        host.wr(8'hDA, 8'h80);
        chk(mode_word_ff, 8'h80);
        host.wr(8'hDA, 8'h00);
        host.wr(8'hDA, 8'h40);
        host.rd(8'hDA, 8'h40, 8'h40, s);
        // Double sync on the second pair of addresses.
        host.wr(8'hDE, 8'h0C);
        host.wr(8'hDE, 8'h16);
        host.wr(8'hDE, 8'h96);
        chk(sync1_ff, 8'h16);
        chk(sync2_ff, 8'h96);
        chk(mode_word_ff, 8'h0C);
        host.rd(8'hDE, 8'h40, 8'h00, s);
        host.wr(8'hDE, 8'hC5);
        host.wr(8'hDA, 8'h4E);
        chk(mode_word_ff, 8'h4E);
        host.wr(8'hD8, 8'hA5);
        chk({7'h00, txd_ff}, 8'h01);
        host.wr(8'hDA, 8'h15);
        host.init_on = 1'b0;
        host.rd(8'hDA, 8'h41, 8'h01, s);
        chk({7'h00, tx_ready_flag_ff}, 8'h01);
        // transmit flag drops after each accepted byte.
        for (int i = 0; i < 3; i++) begin
            d = 8'($random(seed));
            exp_tx.push_back(d);
            host.send(i[0] ? 8'hDC : 8'hD8, d, ok);
            @(negedge clk_sys);
            chk({7'h00, tx_ready_flag_ff}, {7'h00, !ok});
        end
        for (int w = 0; w < 2000 && exp_tx.size() > 0; w++) @(negedge clk_sys);
        chk(8'(exp_tx.size()), 8'h00);
        for (int i = 0; i < 2; i++) begin
            d = 8'($random(seed));
            rx_data = d;
            rx_valid = 1'b1;
            @(negedge clk_sys);
            rx_valid = 1'b0;
            rx_data = ~d;
            chk({7'h00, rx_ready_flag_ff}, 8'h01);
            host.poll(i[0] ? 8'hDE : 8'hDA, 8'h02, ok);
            host.rd(i[0] ? 8'hDC : 8'hD8, 8'hFF, d, s);
            chk({7'h00, rx_ready_flag_ff}, 8'h00);
        end
        // Internal reset with the transmitter enabled, then one odd parity frame.
        host.init_on = 1'b1;
        host.wr(8'hDA, 8'h40);
        chk({7'h00, tx_ready_flag_ff}, 8'h00);
        host.wr(8'hDA, 8'h5E);
        host.wr(8'hDA, 8'h05);
        host.init_on = 1'b0;
        par_on = 1'b1;
        d = 8'($random(seed));
        exp_tx.push_back(d);
        host.send(8'hD8, d, ok);
        for (int w = 0; w < 2000 && exp_tx.size() > 0; w++) @(negedge clk_sys);
        chk(8'(exp_tx.size()), 8'h00);
        host.rd(8'h10, 8'hFF, 8'h00, s);
        // Second hardware reset in mid-run.
        rst = 1'b1;
        @(negedge clk_sys);
        rst = 1'b0;
        host.rd(8'hDA, 8'h43, 8'h40, s);
        results();
    end
endmodule // serial_port_host_programming_tb

// file: bench/spi_host.sv
/*
 * Host CPU model: issues I/O writes and reads and notes expected read data.
 * Assumes the block takes a one-cycle strobe on the next rising clk_sys edge.
 */
`timescale 1ns/1ps
module spi_host
    import spi_pkg::*;
(
    input  wire logic       clk_sys,
    output logic [7:0]      io_addr,
    output logic            io_wr,
    output logic            io_rd,
    output logic [7:0]      io_wdata,
    input  wire logic [7:0] io_rdata_ff
);
    logic [15:0] exp_q[$];  // Mask in the upper byte, value in the lower.
    // writes are spaced by 16 idle cycles of recovery time while init_on is set.
    logic        init_on;

    // Bus idles with no strobe at time zero.
    initial begin
        io_addr  = 8'h00;
        io_wr    = 1'b0;
        io_rd    = 1'b0;
        io_wdata = 8'h00;
    end

    // one write, spaced by the recovery time during initialisation.
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk_sys);
        io_addr  = a;
        io_wdata = d;
        io_wr    = 1'b1;
        @(negedge clk_sys);
        io_wr    = 1'b0;
        io_wdata = ~d;  // A released bus must not show the old byte.
        repeat (init_on ? 16 : 0) @(negedge clk_sys);
    endtask

    // One read; a zero mask marks a poll that is not compared.
    task automatic rd(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e,
                      output logic [7:0] d);
        exp_q.push_back({m, e});
        @(negedge clk_sys);
        io_addr = a;
        io_rd   = 1'b1;
        @(negedge clk_sys);
        io_rd   = 1'b0;
        d       = io_rdata_ff;
    endtask

    // poll status until the masked flag is set.
    task automatic poll(input logic [7:0] a, input logic [7:0] m, output bit ok);
        logic [7:0] s;
        ok = 1'b0;
        for (int i = 0; i < 256 && !ok; i++) begin
            rd(a, 8'h00, 8'h00, s);
            ok = (s & m) != 8'h00;
        end
    endtask

    // data goes out only once the transmit flag is seen.
    task automatic send(input logic [7:0] a, input logic [7:0] d, output bit ok);
        poll(a | 8'h02, 8'h01, ok);
        if (ok) begin
            wr(a, d);
        end
    endtask
endmodule // spi_host

// file: src/spi_core.sv
/*
 * Serial port host programming block: decodes the two address pairs, walks
 * the mode / sync / command sequence, keeps the ready flags and drives the
 * transmit shifter. Assumes host I/O strobes are one-cycle synchronous pulses.
 */
`timescale 1ns/1ps
module spi_core
    import spi_pkg::*;
#(
    parameter int DW = 8
) (
    input  wire logic          clk_sys,
    input  wire logic          rst,
    input  wire logic [7:0]    io_addr,
    input  wire logic          io_wr,
    input  wire logic          io_rd,
    input  wire logic [7:0]    io_wdata,
    output logic [7:0]         io_rdata_ff,
    input  wire logic          rx_valid,
    input  wire logic [DW-1:0] rx_data,
    output logic               tx_ready_flag_ff,
    output logic               rx_ready_flag_ff,
    output logic               txd_ff,
    output logic [7:0]         mode_word_ff,
    output logic [7:0]         sync1_ff,
    output logic [7:0]         sync2_ff
);
    spi_state_e    state_ff;
    spi_state_e    nxt_state;
    logic [7:0]    cmd_ff;
    logic [DW-1:0] hold_ff;
    logic          hold_full_ff;
    logic [DW-1:0] rx_buf_ff;
    logic          overrun_ff;
    logic [5:0]    div_ff;
    logic          tick;
    logic          sh_busy;
    logic          sh_txd;

    // Address pairs decode on the low and high halves.
    // address decode
    wire sel_data = (io_addr == SPI_ADDR_DATA_A) || (io_addr == SPI_ADDR_DATA_B);
    wire sel_ctrl = (io_addr == SPI_ADDR_CTRL_A) || (io_addr == SPI_ADDR_CTRL_B);
    wire ctrl_wr  = io_wr && sel_ctrl;
    wire data_wr  = io_wr && sel_data;
    wire data_rd  = io_rd && sel_data;
    wire is_async = (io_wdata[1:0] != 2'b00);
    wire ir_cmd   = ctrl_wr && (state_ff == SPI_ST_CMD) && io_wdata[SPI_CMD_IR_BIT];
    wire tx_en    = cmd_ff[SPI_CMD_TXEN_BIT];
    wire rx_en    = cmd_ff[SPI_CMD_RXEN_BIT];
    wire data_ok  = data_wr && (state_ff == SPI_ST_CMD) && tx_en && !hold_full_ff;
    wire sh_load  = hold_full_ff && !sh_busy && tx_en;
    wire err_rst  = ctrl_wr && (state_ff == SPI_ST_CMD) && io_wdata[SPI_CMD_ERST_BIT];
    wire ovr_set  = rx_valid && rx_en && rx_ready_flag_ff && !data_rd;

    // Next control write interpretation.
    always_comb begin
        nxt_state = state_ff;
        if (ctrl_wr) begin
            case (state_ff)
                SPI_ST_MODE: begin
                    if (is_async) begin
                        nxt_state = SPI_ST_CMD;
                    end else begin
                        nxt_state = SPI_ST_SYNC1;
                    end
                end
                SPI_ST_SYNC1: begin
                    if (mode_word_ff[SPI_MODE_SCS_BIT]) begin
                        nxt_state = SPI_ST_CMD;
                    end else begin
                        nxt_state = SPI_ST_SYNC2;
                    end
                end
                SPI_ST_SYNC2: nxt_state = SPI_ST_CMD;
                SPI_ST_CMD: nxt_state = ir_cmd ? SPI_ST_MODE : SPI_ST_CMD;
                default: nxt_state = SPI_ST_MODE;
            endcase
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            state_ff <= SPI_ST_MODE;
        end else begin
            state_ff <= nxt_state;
        end
    end

    // Control words land in the register the sequence points at; an internal
    // reset also drops the command so the transmitter idles again.
    // mode word fields
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            mode_word_ff <= SPI_RST_BYTE;
            sync1_ff     <= SPI_RST_BYTE;
            sync2_ff     <= SPI_RST_BYTE;
            cmd_ff       <= SPI_RST_BYTE;
        end else if (ctrl_wr) begin
            case (state_ff)
                SPI_ST_MODE:  mode_word_ff <= io_wdata;
                SPI_ST_SYNC1: sync1_ff <= io_wdata;
                SPI_ST_SYNC2: sync2_ff <= io_wdata;
                SPI_ST_CMD:   cmd_ff <= ir_cmd ? SPI_RST_BYTE : io_wdata;
                default:      cmd_ff <= SPI_RST_BYTE;
            endcase
        end
    end

    // Bit-rate divider, one tick per bit; a fixed factor keeps the shifter simple.
    assign tick = (div_ff == 6'h0);
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            div_ff <= 6'h0;
        end else begin
            div_ff <= tick ? SPI_CHAR_TICKS - 6'h1 : div_ff - 6'h1;
        end
    end

    // Holding buffer: one byte between host and shifter.
    // transmit ready clear
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            hold_full_ff <= 1'b0;
            hold_ff      <= '0;
        end else if (data_ok) begin
            hold_full_ff <= 1'b1;
            hold_ff      <= io_wdata[DW-1:0];
        end else if (sh_load || ir_cmd) begin
            hold_full_ff <= 1'b0;
        end
    end

    // Receive flag: a new byte sets it and wins over a same-cycle read.
    // receive ready clear
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            rx_ready_flag_ff <= 1'b0;
            rx_buf_ff        <= '0;
            overrun_ff       <= 1'b0;
        end else begin
            // A new overrun beats an error reset in the same cycle, so none is lost.
            overrun_ff <= ovr_set || (overrun_ff && !err_rst);
            if (rx_valid && rx_en) begin
                rx_ready_flag_ff <= 1'b1;
                rx_buf_ff        <= rx_data;
            end else if (data_rd) begin
                rx_ready_flag_ff <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            tx_ready_flag_ff <= 1'b0;
        end else begin
            // An internal reset must not leave the flag up while a mode word is awaited.
            tx_ready_flag_ff <= (state_ff == SPI_ST_CMD) && !ir_cmd && tx_en
                                && !hold_full_ff && !data_ok;
        end
    end

    // Read data: status on the high address, received byte on the low one.
    wire [7:0] status = {1'b0, (state_ff == SPI_ST_MODE), 1'b0, overrun_ff, 1'b0,
                         !hold_full_ff && !sh_busy, rx_ready_flag_ff, tx_ready_flag_ff};
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            io_rdata_ff <= SPI_RST_BYTE;
        end else if (io_rd) begin
            io_rdata_ff <= sel_ctrl ? status : (sel_data ? 8'(rx_buf_ff) : SPI_RST_BYTE);
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            txd_ff <= 1'b1;
        end else begin
            txd_ff <= sh_txd;
        end
    end

    spi_shift #(.DW(DW)) u_shift (
        .clk_sys   (clk_sys),
        .rst       (rst),
        .tick      (tick),
        .load      (sh_load),
        .load_data (hold_ff),
        .par_en    (mode_word_ff[SPI_MODE_PEN_BIT]),
        .par_even  (mode_word_ff[SPI_MODE_EP_BIT]),
        .busy_ff   (sh_busy),
        .txd_ff    (sh_txd)
    );

    property p_mode_after_reset;
        @(posedge clk_sys) $fell(rst) |-> state_ff == SPI_ST_MODE;
    endproperty
    a_mode_after_reset: assert property (p_mode_after_reset) else $error("not in mode");
    property p_sync_next;
        @(posedge clk_sys) disable iff (rst)
        ctrl_wr && state_ff == SPI_ST_MODE && !is_async |=> state_ff == SPI_ST_SYNC1;
    endproperty
    a_sync_next: assert property (p_sync_next) else $error("sync skipped");
    property p_cmd_hold;
        @(posedge clk_sys) disable iff (rst)
        state_ff == SPI_ST_CMD && !ir_cmd |=> state_ff == SPI_ST_CMD;
    endproperty
    a_cmd_hold: assert property (p_cmd_hold) else $error("left command state");
    property p_ir;
        @(posedge clk_sys) disable iff (rst) ir_cmd |=> state_ff == SPI_ST_MODE && !tx_en;
    endproperty
    a_ir: assert property (p_ir) else $error("internal reset ignored");
    property p_status_rd;
        @(posedge clk_sys) disable iff (rst)
        io_rd && sel_ctrl |=> io_rdata_ff[SPI_STAT_RX_READY_FLAG] == $past(rx_ready_flag_ff);
    endproperty
    a_status_rd: assert property (p_status_rd) else $error("bad status");
    property p_async_skip;
        @(posedge clk_sys) disable iff (rst)
        ctrl_wr && state_ff == SPI_ST_MODE && is_async |=> state_ff == SPI_ST_CMD;
    endproperty
    a_async_skip: assert property (p_async_skip) else $error("async sync");
    property p_tx_clear;
        @(posedge clk_sys) disable iff (rst) data_ok |=> !tx_ready_flag_ff && hold_full_ff;
    endproperty
    a_tx_clear: assert property (p_tx_clear) else $error("tx_ready_flag stuck");
    property p_ignore;
        @(posedge clk_sys) disable iff (rst)
        data_wr && !tx_en && !hold_full_ff |=> !hold_full_ff;
    endproperty
    a_ignore: assert property (p_ignore) else $error("data accepted");
    property p_rdy;
        @(posedge clk_sys) disable iff (rst)
        tx_ready_flag_ff |-> state_ff == SPI_ST_CMD;
    endproperty
    a_rdy: assert property (p_rdy) else $error("ready too early");
endmodule // spi_core

// file: src/spi_pkg.sv
/*
 * Constants for the serial port programming block: port addresses, control
 * word bit positions, status bit positions and reset values.
 * Assumes a single 100 MHz clock and an 8-bit I/O bus from the host CPU.
 */
package spi_pkg;
    localparam logic [7:0] SPI_ADDR_DATA_A = 8'hD8;
    localparam logic [7:0] SPI_ADDR_CTRL_A = 8'hDA;
    localparam logic [7:0] SPI_ADDR_DATA_B = 8'hDC;
    localparam logic [7:0] SPI_ADDR_CTRL_B = 8'hDE;
    // Mode word fields.
    localparam int SPI_MODE_BAUD_LSB = 0;
    localparam int SPI_MODE_LEN_LSB  = 2;
    localparam int SPI_MODE_PEN_BIT  = 4;
    localparam int SPI_MODE_EP_BIT   = 5;
    localparam int SPI_MODE_ESD_BIT  = 6;
    localparam int SPI_MODE_SCS_BIT  = 7;
    localparam int SPI_MODE_STOP_LSB = 6;
    // Command word fields.
    localparam int SPI_CMD_TXEN_BIT  = 0;
    localparam int SPI_CMD_RXEN_BIT  = 2;
    localparam int SPI_CMD_ERST_BIT  = 4;
    localparam int SPI_CMD_IR_BIT    = 6;
    localparam int SPI_CMD_HUNT_BIT  = 7;
    // Status bit positions.
    localparam int SPI_STAT_TX_READY_FLAG    = 0;
    localparam int SPI_STAT_RX_READY_FLAG    = 1;
    localparam int SPI_STAT_TXEMPTY  = 2;
    localparam int SPI_STAT_PE       = 3;
    localparam int SPI_STAT_OE       = 4;
    localparam int SPI_STAT_FE       = 5;
    localparam int SPI_STAT_HUNT     = 6;
    // Reset values and character timing.
    localparam logic [7:0] SPI_RST_BYTE   = 8'h00;
    localparam logic [5:0] SPI_CHAR_TICKS = 6'h10;
    typedef enum logic [1:0] {
        SPI_ST_MODE,
        SPI_ST_SYNC1,
        SPI_ST_SYNC2,
        SPI_ST_CMD
    } spi_state_e;
endpackage

// file: src/spi_shift.sv
/*
 * Transmit shifter for the serial port: takes one character from the holding
 * buffer and clocks it out one bit per tick with start, parity and stop bits.
 * Assumes tick is a one-cycle enable from the parent's baud divider.
 */
`timescale 1ns/1ps
module spi_shift
    import spi_pkg::*;
#(
    parameter int DW = 8
) (
    input  wire logic          clk_sys,
    input  wire logic          rst,
    input  wire logic          tick,
    input  wire logic          load,
    input  wire logic [DW-1:0] load_data,
    input  wire logic          par_en,
    input  wire logic          par_even,
    output logic               busy_ff,
    output logic               txd_ff
);
    logic [DW+1:0] sh_ff;
    logic [3:0]    cnt_ff;
    logic          par_bit;

    // Parity over the whole character, flipped for odd parity.
    assign par_bit = ^load_data ^ ~par_even;

    // Frame is start bit, data, optional parity, one stop bit; idle line is high.
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            busy_ff <= 1'b0;
            txd_ff  <= 1'b1;
            sh_ff   <= '1;
            cnt_ff  <= 4'h0;
        end else if (load && !busy_ff) begin
            busy_ff <= 1'b1;
            sh_ff   <= {(par_en ? par_bit : 1'b1), load_data, 1'b0};
            cnt_ff  <= par_en ? 4'(DW + 3) : 4'(DW + 2);
        end else if (busy_ff && tick) begin
            txd_ff <= sh_ff[0];
            sh_ff  <= {1'b1, sh_ff[DW+1:1]};
            cnt_ff <= cnt_ff - 4'h1;
            if (cnt_ff == 4'h1) begin
                busy_ff <= 1'b0;
            end
        end
    end
endmodule // spi_shift
